/* File: ret_pkg.sv */
// Shared constants and types of the rotary encoder tracker.
// Assumes one 10 MHz APB clock domain and 32-bit APB data.

package ret_pkg;

	// ==================================================
	// Register map (byte addresses).
	localparam int        ADDR_W    = 8;
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_POS   = 8'h04;
	localparam logic [7:0] OFS_STEP  = 8'h08;
	localparam logic [7:0] OFS_FLOOR = 8'h0C;
	localparam logic [7:0] OFS_CEIL  = 8'h10;
	localparam logic [7:0] OFS_STAT  = 8'h14;

	// ==================================================
	// Status word field positions.
	localparam int STAT_MOVED = 0;
	localparam int STAT_HIT   = 1;
	localparam int STAT_DIR   = 8;
	localparam int STAT_LEVEL = 12;

	// Position number types; float codes are refused.
	typedef enum logic [2:0] {
		CT_S8, CT_S16, CT_S32, CT_U8, CT_U16, CT_U32, CT_F32, CT_F64
	} ret_count_type;

	// Control word, packed from bit 10 down to bit 0.
	typedef struct packed {
		ret_count_type count_type;
		logic          ext_trigger;
		logic          pin_change_mode;
		logic          swap_dir;
		logic          pullup_en;
		logic          gnd_en;
		logic          switch_en;
		logic          clamp_en;
		logic          tracker_on;
	} ret_cfg_type;

	// ==================================================
	// Reset values.
	localparam ret_cfg_type CFG_RESET = '{CT_S8, 1'b0, 1'b0, 1'b0,
		1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	localparam logic [31:0] START_POS   = 32'h00000000;
	localparam logic [31:0] STEP_RESET  = 32'h00000001;
	localparam logic [31:0] FLOOR_RESET = 32'hFFFFFF80;
	localparam logic [31:0] CEIL_RESET  = 32'h0000007F;

	// Debounce interval in tick clocks.
	localparam int SWITCH_SETTLE_CLOCKS = 50;

endpackage

/* File: ret_settle.sv */
// Push-switch debouncer, timed by a one-cycle tick pulse.
// Assumes the level input is already synchronised to pclk.

`timescale 1ns/1ps
`default_nettype none

module ret_settle #(
	parameter int SETTLE = ret_pkg::SWITCH_SETTLE_CLOCKS
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Tick, enable and raw pressed level.
	input  wire logic tick,
	input  wire logic enable,
	input  wire logic level,
	// Debounced level and press pulse.
	output logic      stable_o,
	output logic      hit_o
);
	import ret_pkg::*;

	localparam int CW = $clog2(SETTLE + 1);

	// Counts ticks for which the input disagreed with the output.
	logic [CW-1:0] cnt_r;
	logic          stable_r;
	logic          hit_r;

	// Differing level held for the last needed tick.
	wire differ = level != stable_r;
	wire last   = cnt_r == CW'(SETTLE - 1);
	wire flip   = enable & differ & tick & last;

	if (SETTLE < 1 || SETTLE > 65535) begin : g_bad
		$error("SETTLE out of range");
	end

	// ==================================================
	// Counter: any bounce back restarts the interval.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (!enable || !differ || flip) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

	// Output level and press pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_r <= 1'b0;
			hit_r    <= 1'b0;
		end else begin
			stable_r <= enable & (flip ? level : stable_r);
			hit_r    <= flip & level;
		end
	end

	assign stable_o = stable_r;
	assign hit_o    = hit_r;

	// ==================================================
	// Checks.
	a_settle_time : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(hit_r) |-> $past(cnt_r) == CW'(SETTLE - 1) && $past(tick))
		else $error("press accepted before interval");

endmodule

`default_nettype wire

/* File: ret_tracker.sv */
// Rotary encoder tracker: quadrature decode, position, switch.
// Assumes an APB master on pclk; encoder pins are asynchronous.
//
// Functional notes
// - Polling samples lines on tick rising edge.
// - Pin-change mode; tick only times debounce.
// - Switch accepted after 50 stable ticks.
// - Clamping keeps position within floor/ceiling.
// - Without clamping, position wraps at type.
// - Selectable signed/unsigned 8/16/32 types.
// - Each step adds or subtracts positive step size.
// - Clamped step beyond limit leaves position.
// - Limits ignored while clamping off.
// - Initial value loaded at reset.
// - Switch enable gates press detection.
// - Virtual ground driven low, open drain.
// - Inputs pulled up or high impedance.
// - Swap option reverses counting sense.
// - Polling or pin-change detection selectable.
// - Poll tick from tick or external trigger.
// - Direction +1/-1 kept; 0 after set.
// - Moved and press flags clear on read.
// - Tracker-on gates decoding, not switch.

`timescale 1ns/1ps
`default_nettype none

module ret_tracker #(
	parameter int SETTLE = ret_pkg::SWITCH_SETTLE_CLOCKS
) (
	// Clock and reset.
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ret_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Encoder pins, all asynchronous.
	input  wire logic                      quad_a_i,
	input  wire logic                      quad_b_i,
	input  wire logic                      switch_n_i,
	input  wire logic                      tick_clk_i,
	input  wire logic                      poll_trigger_i,
	// Pin control.
	output logic                           pullup_en_o,
	output logic                           vgnd_o,
	output logic                           vgnd_oe
);
	import ret_pkg::*;

	// ==================================================
	// Input synchronisers.

	// Pin order: trigger, tick, switch, B, A.
	wire [4:0] pin_raw = {poll_trigger_i, tick_clk_i, switch_n_i,
		quad_b_i, quad_a_i};
	logic [4:0] sync1_r; // First stage, read only by stage two.
	logic [4:0] sync2_r; // Stable copy used by the logic.
	logic [1:0] edge_r;  // Previous tick and trigger levels.

	// One pair of flops per pin keeps metastability away.
	for (genvar i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sync1_r[i] <= 1'b1;
				sync2_r[i] <= 1'b1;
			end else begin
				sync1_r[i] <= pin_raw[i];
				sync2_r[i] <= sync1_r[i];
			end
		end
	end

	// Delayed tick and trigger for rising-edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_r <= 2'h3;
		end else begin
			edge_r <= sync2_r[4:3];
		end
	end

	// ==================================================
	// Registers.
	ret_cfg_type cfg_r;   // Control word.
	logic [31:0] pos_r;   // Position, held normalised.
	logic [31:0] step_r;  // Step size.
	logic [31:0] floor_r; // Lower limit.
	logic [31:0] ceil_r;  // Upper limit.
	logic [1:0]  dir_r;   // Last sense: 01 cw, 11 ccw, 00 set.
	logic        moved_r; // Position moved flag.
	logic        hit_r;   // Switch pressed flag.
	logic [1:0]  last_r;  // Last sampled Gray index.
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;

	// ==================================================
	// Number type handling.

	// Cuts a word to the type and extends it to 34 bits.
	function automatic logic signed [33:0] fit(
		input logic [31:0] v, input ret_count_type t);
		unique case (t)
			CT_S8:   return {{26{v[7]}}, v[7:0]};
			CT_S16:  return {{18{v[15]}}, v[15:0]};
			CT_S32:  return {{2{v[31]}}, v};
			CT_U8:   return {26'h0, v[7:0]};
			CT_U16:  return {18'h0, v[15:0]};
			CT_U32:  return {2'h0, v};
			// Float codes never reach the register.
			default: return {2'h0, v};
		endcase
	endfunction

	wire ret_count_type ty = cfg_r.count_type;
	wire signed [33:0] pos_x   = fit(pos_r, ty);
	wire signed [33:0] step_x  = fit(step_r, ty);
	wire signed [33:0] floor_x = fit(floor_r, ty);
	wire signed [33:0] ceil_x  = fit(ceil_r, ty);
	wire signed [33:0] wdat_x  = fit(pwdata, ty);

	// ==================================================
	// Sampling and quadrature decode.

	// Swap exchanges the lines before decoding.
	wire line_a = cfg_r.swap_dir ? sync2_r[1] : sync2_r[0];
	wire line_b = cfg_r.swap_dir ? sync2_r[0] : sync2_r[1];
	// Gray index: 00, 01, 11, 10 map to 0..3.
	wire [1:0] now_idx = {line_a, line_a ^ line_b};

	// Poll tick source: tick pin or shared trigger.
	wire tick_hit = sync2_r[3] & ~edge_r[0];
	wire trig_hit = sync2_r[4] & ~edge_r[1];
	wire poll_hit = cfg_r.ext_trigger ? trig_hit : tick_hit;
	wire pin_chg  = now_idx != last_r;
	// Either polling or pin-change detection drives sampling.
	wire sample   = cfg_r.pin_change_mode ? pin_chg : poll_hit;
	wire live     = sample & cfg_r.tracker_on;
	// Only neighbouring Gray codes are steps; skips are bounce.
	wire step_cw  = live & (now_idx == last_r + 2'h1);
	wire step_ccw = live & (now_idx == last_r - 2'h1);
	wire step_any = step_cw | step_ccw;

	// ==================================================
	// Position arithmetic.
	wire signed [33:0] cand = step_cw ? pos_x + step_x : pos_x - step_x;
	// Limits only matter while clamping is on.
	wire over = cfg_r.clamp_en & ((cand > ceil_x) | (cand < floor_x));
	wire signed [33:0] wrap_x = fit(cand[31:0], ty);
	wire [31:0] pos_nxt = over ? pos_r : wrap_x[31:0];
	wire pos_moves = step_any & (pos_nxt != pos_r);

	// ==================================================
	// Switch debounce.

	// External-trigger polling has no tick pin, so the trigger times it.
	wire sw_tick = cfg_r.ext_trigger & ~cfg_r.pin_change_mode ?
		trig_hit : tick_hit;
	wire sw_level;
	wire sw_hit;

	ret_settle #(
		.SETTLE (SETTLE)
	) u_settle (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (sw_tick),
		.enable   (cfg_r.switch_en),
		.level    (~sync2_r[2]),
		.stable_o (sw_level),
		.hit_o    (sw_hit)
	);

	// ==================================================
	// APB decode.
	wire setup    = psel & ~penable;
	wire done     = psel & penable & pready_r;
	wire wr       = done & pwrite;
	wire sel_ctrl = paddr == OFS_CTRL;
	wire sel_pos  = paddr == OFS_POS;
	wire sel_step = paddr == OFS_STEP;
	wire sel_flr  = paddr == OFS_FLOOR;
	wire sel_ceil = paddr == OFS_CEIL;
	wire sel_stat = paddr == OFS_STAT;
	wire addr_ok  = sel_ctrl | sel_pos | sel_step | sel_flr |
		sel_ceil | sel_stat;
	wire pos_wr   = wr & sel_pos;
	wire stat_rd  = done & ~pwrite & sel_stat;

	// Float codes are refused: the type stays as it was.
	wire is_float = pwdata[10:8] == 3'(CT_F32) ||
		pwdata[10:8] == 3'(CT_F64);
	wire ret_cfg_type cfg_wr = is_float ?
		{ty, pwdata[7:0]} : ret_cfg_type'(pwdata[10:0]);

	// Status word as seen by a read.
	wire [31:0] stat_w = (32'(moved_r) << STAT_MOVED) |
		(32'(hit_r) << STAT_HIT) | (32'(dir_r) << STAT_DIR) |
		(32'(sw_level) << STAT_LEVEL);

	// Read mux; unmapped reads return zero.
	wire [31:0] rd_word =
		sel_ctrl ? {21'h0, cfg_r} :
		sel_pos  ? pos_x[31:0] :
		sel_step ? step_x[31:0] :
		sel_flr  ? floor_x[31:0] :
		sel_ceil ? ceil_x[31:0] :
		sel_stat ? stat_w : 32'h0;

	// Flags: an event beats the clear, and a read only clears what
	// it actually returned.
	wire moved_nxt = pos_moves | (moved_r &
		~(stat_rd & prdata_r[STAT_MOVED]));
	wire hit_nxt   = sw_hit | (hit_r &
		~(stat_rd & prdata_r[STAT_HIT]));

	// ==================================================
	// Bus answer: one wait-free access phase after setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~addr_ok;
			prdata_r  <= setup & ~pwrite ? rd_word : 32'h0;
		end
	end

	// ==================================================
	// Configuration registers; writes land at the access edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r   <= CFG_RESET;
			step_r  <= STEP_RESET;
			floor_r <= FLOOR_RESET;
			ceil_r  <= CEIL_RESET;
		end else begin
			if (wr & sel_ctrl) begin
				cfg_r <= cfg_wr;
			end
			// A zero or negative step is refused.
			if (wr & sel_step & (wdat_x > 34'sh0)) begin
				step_r <= pwdata;
			end
			if (wr & sel_flr) begin
				floor_r <= pwdata;
			end
			if (wr & sel_ceil) begin
				ceil_r <= pwdata;
			end
		end
	end

	// ==================================================
	// Position and direction; a software set beats a step.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r <= START_POS;
			dir_r <= 2'h0;
		end else if (pos_wr) begin
			pos_r <= wdat_x[31:0];
			dir_r <= 2'h0;
		end else if (step_any) begin
			pos_r <= pos_nxt;
			// Sense is kept even when the position sticks or wraps.
			dir_r <= step_cw ? 2'h1 : 2'h3;
		end
	end

	// Gray tracking follows every sample, so re-enabling the
	// tracker does not count a stale jump.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= 2'h2;
		end else if (sample) begin
			last_r <= now_idx;
		end
	end

	// Flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			moved_r <= 1'b0;
			hit_r   <= 1'b0;
		end else begin
			moved_r <= moved_nxt;
			hit_r   <= hit_nxt;
		end
	end

	// Pin control: the ground pin only ever sinks, never sources.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_en_o <= 1'b0;
			vgnd_oe     <= 1'b0;
		end else begin
			pullup_en_o <= cfg_r.pullup_en;
			vgnd_oe     <= cfg_r.gnd_en;
		end
	end

	assign vgnd_o  = 1'b0;
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ==================================================
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_poll_edge : assert property (
		!cfg_r.pin_change_mode && step_any |-> poll_hit)
		else $error("poll step without tick");

	a_change_only : assert property (
		cfg_r.pin_change_mode && sample |-> now_idx != last_r)
		else $error("pin-change sample without change");

	a_clamp_hold : assert property (
		step_any && over && !pos_wr |=> $stable(pos_r) && !$rose(moved_r))
		else $error("clamped step moved position");

	a_wrap_s8 : assert property (
		step_cw && !cfg_r.clamp_en && ty == CT_S8 && pos_r[7:0] == 8'h7F
		&& step_x == 34'sh1 && !pos_wr |=> pos_r == 32'hFFFFFF80)
		else $error("int8 did not wrap to -128");

	a_step_add : assert property (
		step_cw && !cfg_r.clamp_en && ty == CT_S32 && !pos_wr
		|=> pos_r == $past(pos_r) + $past(step_r))
		else $error("step size not applied");

	a_dir_kept : assert property (
		step_ccw && !pos_wr |=> dir_r == 2'h3 && (moved_r || !$past(pos_moves)))
		else $error("direction not recorded");

	a_tracker_off : assert property (
		!cfg_r.tracker_on |-> !step_any)
		else $error("step while tracker off");

	a_switch_off : assert property (
		!cfg_r.switch_en |=> !sw_hit)
		else $error("press while switch disabled");

	a_vgnd_low : assert property (
		$past(presetn) |-> vgnd_oe == $past(cfg_r.gnd_en) && !vgnd_o)
		else $error("virtual ground wrong");

	a_flag_clear : assert property (
		stat_rd && prdata_r[STAT_HIT] && !sw_hit |=> !hit_r)
		else $error("press flag not cleared by read");

	c_wrap : cover property (step_cw && !over && pos_x > wrap_x);
	c_clamp : cover property (step_any && over);
	c_press : cover property (sw_hit);
	c_read_clear : cover property (stat_rd && prdata_r[STAT_MOVED]);

endmodule

`default_nettype wire

/* File: ret_encoder_model.sv */
// Behavioural rotary encoder: quadrature contacts, push switch, tick and trigger.
// Assumes the bench calls its tasks; the contacts rest at the pulled-up detent.
`timescale 1ns/1ps
`default_nettype none
module ret_encoder_model #(
	parameter int TICK_HALF = 730
) (
	// Encoder lines and switch.
	output logic quad_a,
	output logic quad_b,
	output logic switch_n,
	// Tick clock and shared poll trigger.
	output logic tick_clk,
	output logic poll_trig
);
	// Gray index: 0..3 stands for 00, 01, 11, 10 on (A,B).
	int idx = 2;
	// Running source: 0 tick clock, 1 trigger, 2 none.
	int src = 0;
	initial begin
		{quad_a, quad_b} = 2'b11;
		switch_n = 1'b1;
		tick_clk = 1'b0;
		poll_trig = 1'b0;
	end
	// The tick is scaled down to keep runs short; a stopped source rests low.
	always begin
		#(TICK_HALF);
		tick_clk = (src == 0) ? ~tick_clk : 1'b0;
		poll_trig = (src == 1) ? ~poll_trig : 1'b0;
	end
	// Each state is held two tick periods so a poll always sees it; step 2 is an illegal jump.
	task automatic turn(input int step, input int n);
		for (int i = 0; i < n; i++) begin
			idx = (idx + step) & 3;
			{quad_a, quad_b} = (idx == 0) ? 2'b00 : (idx == 1) ? 2'b01 :
				(idx == 2) ? 2'b11 : 2'b10;
			#(4 * TICK_HALF);
		end
	endtask
	// Contact bounce first, then a steady press for the given tick count.
	task automatic press(input int ticks);
		repeat (3) begin
			switch_n = ~switch_n;
			#150;
		end
		#(2 * TICK_HALF * ticks);
	endtask
	// Release and wait long enough for the debouncer to follow.
	task automatic let_go(input int ticks);
		switch_n = 1'b1;
		#(2 * TICK_HALF * ticks);
	endtask
endmodule
`default_nettype wire

/* File: tb_rotary_encoder_tracker.sv */
// Self-checking bench for the encoder tracker over APB.
// Assumes the encoder model drives the pins; SETTLE is shortened to 3 ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_rotary_encoder_tracker;
	import ret_pkg::*;
	localparam int SETTLE = 3;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic e;} ret_note_type;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rv;
	logic              pready, pslverr, qa, qb, sw_n, tick, trig, pull, vgnd, vgnd_oe;
	int                n_errors = 0;
	int                checks = 0;
	integer            seed = 32'h9588;
	ret_note_type      notes[$];
	ret_note_type      note;
	// Largest value of each type and what one step up from it gives.
	logic [31:0] top [6] = '{32'h7F, 32'h7FFF, 32'h7FFFFFFF, 32'hFF, 32'hFFFF, 32'hFFFFFFFF};
	logic [31:0] wrp [6] = '{32'hFFFFFF80, 32'hFFFF8000, 32'h80000000, 32'h0, 32'h0, 32'h0};

	ret_tracker #(.SETTLE(SETTLE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .quad_a_i(qa), .quad_b_i(qb), .switch_n_i(sw_n),
		.tick_clk_i(tick), .poll_trigger_i(trig), .pullup_en_o(pull), .vgnd_o(vgnd),
		.vgnd_oe(vgnd_oe));
	ret_encoder_model enc (.quad_a(qa), .quad_b(qb), .switch_n(sw_n), .tick_clk(tick),
		.poll_trig(trig));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; the expected answer is queued before the request goes out.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		notes.push_back('{a, wr ? 32'h0 : d, wr ? 32'h0 : m, a > OFS_STAT});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wr ? d : $random(seed);
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle address and direction are don't-care; random values prove it.
		paddr <= 8'($random(seed));
		pwrite <= 1'($random(seed));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, m);
	endtask

	// Watches completed transfers and compares each with the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			chk($sformatf("reg %h", note.a), note.d & note.m, prdata & note.m);
			chk("pslverr", {31'h0, note.e}, {31'h0, pslverr});
		end
	end

	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test();
		// A note left in the queue is a transfer that never completed.
		if (notes.size() != 0) begin
			n_errors++;
			$display("BAD queue expected 0 seen %0d", notes.size());
		end
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a millisecond.
	initial begin
		#(2_000_000);
		n_errors++;
		$display("BAD watchdog expected done seen timeout");
		finish_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CTRL, 32'h1D, '1);
		rd(OFS_POS, 32'h0, '1);
		rd(OFS_STEP, 32'h1, '1);
		rd(OFS_FLOOR, 32'hFFFFFF80, '1);
		rd(OFS_CEIL, 32'h7F, '1);
		rd(OFS_STAT, 32'h0, 32'h303);
		rd(8'h18, 32'h0, '1);
		chk("pullup_en_o", 32'h1, {31'h0, pull});
		chk("vgnd", 32'h2, {30'h0, vgnd_oe, vgnd});
		done("reset");
		enc.turn(1, 4);
		rd(OFS_POS, 32'h4, '1);
		rd(OFS_STAT, 32'h101, 32'h303);
		rd(OFS_STAT, 32'h0, 32'h1);
		wr(OFS_STEP, 32'h0);
		rd(OFS_STEP, 32'h1, '1);
		wr(OFS_STEP, 32'h3);
		enc.turn(2, 2);
		rd(OFS_POS, 32'h4, '1);
		enc.turn(-1, 2);
		rd(OFS_POS, 32'hFFFFFFFE, '1);
		rd(OFS_STAT, 32'h300, 32'h300);
		done("steps");
		wr(OFS_CTRL, 32'h21);
		wr(OFS_POS, 32'h0);
		enc.turn(1, 1);
		rd(OFS_POS, 32'hFFFFFFFD, '1);
		chk("pullup_en_o", 32'h0, {31'h0, pull});
		chk("vgnd_oe", 32'h0, {31'h0, vgnd_oe});
		enc.press(6);
		enc.let_go(6);
		rd(OFS_STAT, 32'h0, 32'h2);
		done("swap");
		wr(OFS_CTRL, 32'h1C);
		rd(OFS_STAT, 32'h300, 32'h303);
		enc.turn(1, 2);
		rd(OFS_POS, 32'hFFFFFFFD, '1);
		rd(OFS_STAT, 32'h0, 32'h1);
		enc.press(1);
		enc.let_go(6);
		rd(OFS_STAT, 32'h0, 32'h2);
		enc.press(6);
		rd(OFS_STAT, 32'h2, 32'h3);
		enc.let_go(6);
		rd(OFS_STAT, 32'h0, 32'h2);
		done("switch");
		wr(OFS_CTRL, 32'h5D);
		wr(OFS_STEP, 32'h1);
		wr(OFS_POS, 32'h0);
		enc.src = 2;
		enc.turn(1, 1);
		rd(OFS_POS, 32'h1, '1);
		wr(OFS_CTRL, 32'h9D);
		enc.src = 1;
		enc.turn(1, 1);
		rd(OFS_POS, 32'h2, '1);
		enc.src = 2;
		enc.turn(1, 4);
		rd(OFS_POS, 32'h2, '1);
		enc.src = 0;
		done("modes");
		wr(OFS_FLOOR, 32'h0);
		wr(OFS_CEIL, 32'h1);
		for (int t = 0; t < 6; t++) begin
			wr(OFS_CTRL, {21'h0, t[2:0], 8'h1D});
			wr(OFS_POS, top[t]);
			rd(OFS_STAT, 32'h0, 32'h300);
			enc.turn(1, 1);
			rd(OFS_POS, wrp[t], '1);
			rd(OFS_STAT, 32'h101, 32'h301);
		end
		done("wrap");
		wr(OFS_CTRL, 32'h31F);
		wr(OFS_CEIL, 32'hFF);
		wr(OFS_STEP, 32'h0A);
		wr(OFS_POS, 32'hF0);
		enc.turn(1, 2);
		rd(OFS_POS, 32'hFA, '1);
		rd(OFS_STAT, 32'h101, 32'h301);
		wr(OFS_POS, 32'h5);
		enc.turn(-1, 1);
		rd(OFS_POS, 32'h5, '1);
		rd(OFS_STAT, 32'h300, 32'h301);
		done("clamp");
		wr(OFS_CTRL, 32'h61D);
		rd(OFS_CTRL, 32'h31D, '1);
		wr(OFS_CTRL, 32'h21D);
		rv = $random(seed);
		wr(OFS_POS, rv);
		rd(OFS_POS, rv, '1);
		enc.turn(1, 2);
		rd(OFS_POS, rv + 32'h14, '1);
		done("types");
		// Second reset in mid-run; the lines rest at the reset Gray state.
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CTRL, 32'h1D, '1);
		rd(OFS_POS, 32'h0, '1);
		rd(OFS_STAT, 32'h0, 32'h303);
		done("reset again");
		repeat (4) @(posedge pclk);
		finish_test();
	end
endmodule
`default_nettype wire
